// [rtl/fcd_dma_ctrl.v]
// Control, status and arbitration logic of the five-channel DMA controller
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "fcd_dma_defines.vh"

module fcd_dma_ctrl (
  input wire core_clk,
  input wire resetn,
  input wire [8:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [31:0] regRdData,
  input wire [4:0] drqLine,
  input wire [4:1] chRun,
  input wire [4:1] chHalfEvt,
  input wire [4:1] chDoneEvt,
  input wire ch0Error,
  output reg [4:0] busGrant,
  output reg [18:0] ch0SrcAddr,
  output reg [18:0] ch0DstAddr,
  output reg [2:0] ch0WidthBytes,
  output reg ch0Active,
  output reg [4:0] cpuIrq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] rankTableCode;
  reg [4:0] halfPending;
  reg [4:0] donePending;
  reg [4:0] halfIrqOn;
  reg [4:0] doneIrqOn;
  reg ch0GoBit;
  reg reloadOn;
  reg wordSizeSelect;
  reg [3:0] targetKind;
  reg [3:0] originKind;
  reg [18:0] ch0OriginPointer;
  reg [18:0] ch0TargetPointer;
  reg [17:0] ch0FrameCount;
  reg [3:0] runSrcKind;
  reg [3:0] runDstKind;
  reg runWidthSel;
  reg [17:0] remainCount;
  reg [17:0] halfMark;
  reg halfSent;

  wire wrCtl, goRise;
  wire [2:0] progBytes;
  wire [2:0] runBytes;
  wire [3:0] progSrcKind, progDstKind;
  wire progWidthSel;
  wire fifoCount;
  wire [2:0] countStep;
  wire req0;
  wire [4:0] eligible, nextGrant;
  wire ch0Finish, ch0Half;
  wire [4:0] halfEvt, doneEvt;
  wire [4:0] clrHalf, clrDone;
  wire [4:0] next_halfPending, next_donePending;
  reg [31:0] next_rdData;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Bytes per access; the peripheral end decides, memory ends take 32 bits
  function [2:0] bytesOf;
    input [3:0] srcK;
    input [3:0] dstK;
    input sel;
    begin
      bytesOf = `FCD_B4;
      if (dstK == `FCD_KD_I2S || srcK == `FCD_KS_I2S) begin
        bytesOf = sel ? `FCD_B3 : `FCD_B2;
      end else if (dstK == `FCD_K_SPI1 || srcK == `FCD_K_SPI1) begin
        bytesOf = sel ? `FCD_B4 : `FCD_B1;
      end else if (dstK == `FCD_K_UART0 || dstK == `FCD_K_UART1 ||
                   srcK == `FCD_K_UART0 || srcK == `FCD_K_UART1) begin
        bytesOf = `FCD_B1;
      end else if (dstK == `FCD_KD_LCD || srcK == `FCD_KS_ADC) begin
        bytesOf = `FCD_B2;
      end
    end
  endfunction

  // Endpoints whose frame is counted in FIFO accesses
  function isFifo;
    input [3:0] srcK;
    input [3:0] dstK;
    begin
      isFifo = (dstK == `FCD_KD_LCD) || (dstK == `FCD_KD_I2S) ||
               (dstK == `FCD_K_SPI1) || (dstK == `FCD_K_SPI0) ||
               (dstK == `FCD_KD_MODEM) || (srcK == `FCD_KS_ADC) ||
               (srcK == `FCD_K_SPI1) || (srcK == `FCD_K_SPI0) ||
               (srcK == `FCD_KS_MODEM);
    end
  endfunction

  // Drops the address bits that a wide access cannot use
  function [18:0] alignAddr;
    input [18:0] a;
    input [2:0] nb;
    begin
      alignAddr = a;
      if (nb == `FCD_B2) begin
        alignAddr[0] = 1'b0;
      end else if (nb == `FCD_B4) begin
        alignAddr[1:0] = 2'b00;
      end
    end
  endfunction

  // Memory-like ends walk through addresses, FIFO ends stay put
  function isMemKind;
    input [3:0] k;
    begin
      isMemKind = (k == `FCD_K_MEM) || (k == `FCD_K_BBRAM);
    end
  endfunction

  // One-hot pick of the highest ranked request
  function [4:0] pickGrant;
    input [2:0] code;
    input [4:0] req;
    integer i;
    reg [2:0] first;
    reg found;
    begin
      pickGrant = 5'h00;
      found = 1'b0;
      first = (code <= `FCD_RANK_LAST) ? code : 3'h0;
      if (req[first]) begin
        pickGrant[first] = 1'b1;
        found = 1'b1;
      end
      for (i = 0; i < 5; i = i + 1) begin
        if (!found && i != first && req[i]) begin
          pickGrant[i] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Channel 0 engine
  // ----------------------------------------
  assign wrCtl = regWrEn && (regAddr == `FCD_OFS_CTL0);
  assign goRise = wrCtl && regWrData[`FCD_CTL_GO] && !ch0GoBit;
  assign progSrcKind = wrCtl ? regWrData[`FCD_CTL_SRC_HI:`FCD_CTL_SRC_LO] : originKind;
  assign progDstKind = wrCtl ? regWrData[`FCD_CTL_DST_HI:`FCD_CTL_DST_LO] : targetKind;
  assign progWidthSel = wrCtl ? regWrData[`FCD_CTL_WIDTH] : wordSizeSelect;
  assign progBytes = bytesOf(progSrcKind, progDstKind, progWidthSel);
  assign runBytes = bytesOf(runSrcKind, runDstKind, runWidthSel);
  assign fifoCount = isFifo(runSrcKind, runDstKind);
  assign countStep = fifoCount ? `FCD_B1 : runBytes;
  assign req0 = ch0Active && drqLine[0] && (remainCount != 18'h00000);
  assign eligible = {chRun & drqLine[4:1], req0};
  assign nextGrant = pickGrant(rankTableCode, eligible);
  assign ch0Finish = ch0Active && (remainCount == 18'h00000);
  // Half point is reached once at most half of the frame, rounded up, is left
  assign ch0Half = ch0Active && !halfSent && (remainCount <= halfMark);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ch0GoBit <= 1'b0;
      reloadOn <= 1'b0;
      wordSizeSelect <= 1'b0;
      targetKind <= 4'h0;
      originKind <= 4'h0;
      ch0OriginPointer <= 19'h00000;
      ch0TargetPointer <= 19'h00000;
      ch0FrameCount <= 18'h00000;
      runSrcKind <= 4'h0;
      runDstKind <= 4'h0;
      runWidthSel <= 1'b0;
      remainCount <= 18'h00000;
      halfMark <= 18'h00000;
      halfSent <= 1'b0;
      ch0Active <= 1'b0;
      ch0SrcAddr <= 19'h00000;
      ch0DstAddr <= 19'h00000;
      ch0WidthBytes <= 3'h0;
    end else begin
      if (regWrEn && regAddr == `FCD_OFS_SRC0) begin
        ch0OriginPointer <= regWrData[`FCD_ADDR_W-1:0];
      end
      if (regWrEn && regAddr == `FCD_OFS_DST0) begin
        ch0TargetPointer <= regWrData[`FCD_ADDR_W-1:0];
      end
      if (regWrEn && regAddr == `FCD_OFS_LEN0) begin
        ch0FrameCount <= regWrData[`FCD_LEN_W-1:0];
      end
      // Progress of the running frame
      if (nextGrant[0]) begin
        remainCount <= (remainCount < {15'h0000, countStep}) ?
                       18'h00000 : remainCount - {15'h0000, countStep};
        if (isMemKind(runSrcKind)) begin
          ch0SrcAddr <= ch0SrcAddr + {16'h0000, runBytes};
        end
        if (isMemKind(runDstKind)) begin
          ch0DstAddr <= ch0DstAddr + {16'h0000, runBytes};
        end
      end
      if (ch0Half) begin
        halfSent <= 1'b1;
      end
      // Completion, error and reload; the go bit clears on error, or on completion unless reloading
      if (ch0Active && ch0Error) begin
        ch0Active <= 1'b0;
        ch0GoBit <= 1'b0;
      end else if (ch0Finish && !reloadOn) begin
        ch0Active <= 1'b0;
        ch0GoBit <= 1'b0;
      end
      // Software write to control; a fresh start or reload relatches
      if (wrCtl) begin
        wordSizeSelect <= regWrData[`FCD_CTL_WIDTH];
        targetKind <= regWrData[`FCD_CTL_DST_HI:`FCD_CTL_DST_LO];
        originKind <= regWrData[`FCD_CTL_SRC_HI:`FCD_CTL_SRC_LO];
        reloadOn <= regWrData[`FCD_CTL_RELOAD];
        ch0GoBit <= regWrData[`FCD_CTL_GO];
        if (!regWrData[`FCD_CTL_GO]) begin
          ch0Active <= 1'b0;
        end
      end
      if (goRise || (ch0Finish && reloadOn && !ch0Error && !wrCtl)) begin
        // A start takes the kinds from the same write, so they apply at once
        ch0Active <= 1'b1;
        runSrcKind <= progSrcKind;
        runDstKind <= progDstKind;
        runWidthSel <= progWidthSel;
        ch0WidthBytes <= progBytes;
        ch0SrcAddr <= alignAddr(ch0OriginPointer, progBytes);
        ch0DstAddr <= alignAddr(ch0TargetPointer, progBytes);
        remainCount <= ch0FrameCount;
        halfMark <= ch0FrameCount - (ch0FrameCount >> 1);
        halfSent <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Arbiter
  // ----------------------------------------
  // Each grant is one access; a channel re-requests for the next one
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busGrant <= 5'h00;
    end else begin
      busGrant <= nextGrant;
    end
  end

  // ----------------------------------------
  // Pending flags, per channel
  // ----------------------------------------
  assign halfEvt = {chHalfEvt, ch0Half};
  assign doneEvt = {chDoneEvt, ch0Finish};
  assign clrHalf = (regWrEn && regAddr == `FCD_OFS_PEND) ?
                   regWrData[`FCD_HALF_HI:`FCD_HALF_LO] : 5'h00;
  assign clrDone = (regWrEn && regAddr == `FCD_OFS_PEND) ?
                   regWrData[`FCD_DONE_HI:`FCD_DONE_LO] : 5'h00;

  genvar ch;
  generate
    for (ch = 0; ch < 5; ch = ch + 1) begin : gPend
      // A new event in the clearing cycle is kept
      assign next_halfPending[ch] = (halfPending[ch] & ~clrHalf[ch]) | halfEvt[ch];
      assign next_donePending[ch] = (donePending[ch] & ~clrDone[ch]) | doneEvt[ch];
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          halfPending[ch] <= 1'b0;
          donePending[ch] <= 1'b0;
          cpuIrq[ch] <= 1'b0;
        end else begin
          halfPending[ch] <= next_halfPending[ch];
          donePending[ch] <= next_donePending[ch];
          cpuIrq[ch] <= (next_halfPending[ch] & halfIrqOn[ch]) |
                        (next_donePending[ch] & doneIrqOn[ch]);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Rank and enable registers
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rankTableCode <= 3'h0;
      halfIrqOn <= 5'h00;
      doneIrqOn <= 5'h00;
    end else begin
      if (regWrEn && regAddr == `FCD_OFS_RANK) begin
        rankTableCode <= regWrData[`FCD_RANK_HI:0];
      end
      if (regWrEn && regAddr == `FCD_OFS_IEN) begin
        halfIrqOn <= regWrData[`FCD_HALF_HI:`FCD_HALF_LO];
        doneIrqOn <= regWrData[`FCD_DONE_HI:`FCD_DONE_LO];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Reserved and unmapped bits read as zero
  always @* begin
    next_rdData = `FCD_RESET_VAL;
    case (regAddr)
      `FCD_OFS_RANK: next_rdData[`FCD_RANK_HI:0] = rankTableCode;
      `FCD_OFS_PEND: begin
        next_rdData[`FCD_HALF_HI:`FCD_HALF_LO] = halfPending;
        next_rdData[`FCD_DONE_HI:`FCD_DONE_LO] = donePending;
      end
      `FCD_OFS_IEN: begin
        next_rdData[`FCD_HALF_HI:`FCD_HALF_LO] = halfIrqOn;
        next_rdData[`FCD_DONE_HI:`FCD_DONE_LO] = doneIrqOn;
      end
      `FCD_OFS_CTL0: begin
        next_rdData[`FCD_CTL_WIDTH] = wordSizeSelect;
        next_rdData[`FCD_CTL_DST_HI:`FCD_CTL_DST_LO] = targetKind;
        next_rdData[`FCD_CTL_SRC_HI:`FCD_CTL_SRC_LO] = originKind;
        next_rdData[`FCD_CTL_RELOAD] = reloadOn;
        next_rdData[`FCD_CTL_GO] = ch0GoBit;
      end
      `FCD_OFS_SRC0: next_rdData[`FCD_ADDR_W-1:0] = ch0OriginPointer;
      `FCD_OFS_DST0: next_rdData[`FCD_ADDR_W-1:0] = ch0TargetPointer;
      `FCD_OFS_LEN0: next_rdData[`FCD_LEN_W-1:0] = ch0FrameCount;
      `FCD_OFS_REM0: next_rdData[`FCD_LEN_W-1:0] = remainCount;
      default: next_rdData = `FCD_RESET_VAL;
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= `FCD_RESET_VAL;
    end else if (regRdEn) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= `FCD_RESET_VAL;
    end
  end

endmodule // fcd_dma_ctrl

// [rtl/fcd_dma_defines.vh]
// Register map, field positions and endpoint codes of the DMA control block
`ifndef FCD_DMA_DEFINES_VH
`define FCD_DMA_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FCD_OFS_RANK 9'h000
`define FCD_OFS_PEND 9'h004
`define FCD_OFS_IEN 9'h008
`define FCD_OFS_CTL0 9'h010
`define FCD_OFS_SRC0 9'h014
`define FCD_OFS_DST0 9'h018
`define FCD_OFS_LEN0 9'h01C
`define FCD_OFS_REM0 9'h100

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define FCD_RANK_HI 2
`define FCD_HALF_LO 8
`define FCD_HALF_HI 12
`define FCD_DONE_LO 0
`define FCD_DONE_HI 4
`define FCD_CTL_GO 0
`define FCD_CTL_RELOAD 1
`define FCD_CTL_SRC_LO 4
`define FCD_CTL_SRC_HI 7
`define FCD_CTL_DST_LO 8
`define FCD_CTL_DST_HI 11
`define FCD_CTL_WIDTH 12
`define FCD_ADDR_W 19
`define FCD_LEN_W 18
`define FCD_RESET_VAL 32'h0000_0000

// ----------------------------------------
// Priority codes
// ----------------------------------------
`define FCD_RANK_LAST 3'h4

// ----------------------------------------
// Endpoint kind codes
// ----------------------------------------
`define FCD_K_MEM 4'h0
`define FCD_K_BBRAM 4'h1
`define FCD_KD_MODEM 4'h2
`define FCD_K_UART0 4'h3
`define FCD_KD_I2S 4'h5
`define FCD_KS_MODEM 4'h4
`define FCD_KS_ADC 4'h5
`define FCD_K_SD 4'h6
`define FCD_K_SD1 4'h7
`define FCD_K_UART1 4'h8
`define FCD_K_SPI1 4'h9
`define FCD_KS_I2S 4'hA
`define FCD_KD_LCD 4'hC
`define FCD_K_SPI0 4'hD

// ----------------------------------------
// Bytes per access
// ----------------------------------------
`define FCD_B1 3'h1
`define FCD_B2 3'h2
`define FCD_B3 3'h3
`define FCD_B4 3'h4

`endif

// [verif/fcd_dma_checker.sv]
// Port-level assertions for the DMA control block
`timescale 1ns/100ps
`include "fcd_dma_defines.vh"
module fcd_dma_checker (
  input wire core_clk,
  input wire resetn,
  input wire [8:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [31:0] regRdData,
  input wire [4:0] drqLine,
  input wire [4:1] chRun,
  input wire [4:1] chHalfEvt,
  input wire [4:1] chDoneEvt,
  input wire ch0Error,
  input wire [4:0] busGrant,
  input wire [18:0] ch0SrcAddr,
  input wire [18:0] ch0DstAddr,
  input wire [2:0] ch0WidthBytes,
  input wire ch0Active,
  input wire [4:0] cpuIrq
);
  // ----------------------------------------
  // Shadow copies of written registers
  // ----------------------------------------
  reg [2:0] rank;
  reg [31:0] ien;
  reg [12:0] ctl;
  reg [17:0] len;
  wire ctlWr = regWrEn && regAddr == `FCD_OFS_CTL0;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rank <= 3'h0;
      ien <= 32'h0;
      ctl <= 13'h0;
      len <= 18'h0;
    end else if (regWrEn) begin
      if (regAddr == `FCD_OFS_RANK) rank <= regWrData[2:0];
      if (regAddr == `FCD_OFS_IEN) ien <= regWrData;
      if (ctlWr) ctl <= regWrData[12:0];
      if (regAddr == `FCD_OFS_LEN0) len <= regWrData[17:0];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_grant_onehot: assert property ($onehot0(busGrant))
    else $error("more than one channel granted");
  a_rank_top: assert property (rank >= 3'h1 && rank <= 3'h4 && chRun[rank] && drqLine[rank]
    |=> busGrant == (5'h01 << $past(rank))) else $error("top ranked channel not granted");
  a_rank_default: assert property ((rank == 3'h0 || rank > 3'h4) && chRun[1] && drqLine[1]
    |=> busGrant[4:2] == 3'h0) else $error("default order broken");
  a_irq_masked: assert property ((cpuIrq & ~($past(ien[12:8]) | $past(ien[4:0]))) == 5'h00)
    else $error("interrupt without enable");
  a_done_irq: assert property (chDoneEvt[3] && ien[3] |-> ##[1:2] cpuIrq[3])
    else $error("complete event gave no interrupt");
  a_half_irq: assert property (chHalfEvt[2] && ien[10] |-> ##[1:2] cpuIrq[2])
    else $error("half event gave no interrupt");
  a_go_starts: assert property (ctlWr && regWrData[0] && !ch0Active && len != 18'h0
    |-> ##[1:2] ch0Active) else $error("start did not run channel");
  a_abort_stops: assert property (ch0Active && ctlWr && !regWrData[0] |-> ##[1:2] !ch0Active)
    else $error("abort ignored");
  a_error_stops: assert property (ch0Active && ch0Error |-> ##[1:2] !ch0Active)
    else $error("error did not stop channel");
  a_i2s_width: assert property ($rose(ch0Active) && ctl[11:8] == 4'h5
    |-> ch0WidthBytes == (ctl[12] ? 3'h3 : 3'h2)) else $error("audio width wrong");
  a_spi1_width: assert property ($rose(ch0Active) && ctl[7:4] == 4'h9 && ctl[11:8] == 4'h0
    |-> ch0WidthBytes == (ctl[12] ? 3'h4 : 3'h1)) else $error("serial width wrong");
  a_addr_aligned: assert property (ch0Active && ch0WidthBytes == 3'h4
    |-> ch0SrcAddr[1:0] == 2'h0 && ch0DstAddr[1:0] == 2'h0) else $error("address not aligned");
  cover property ($rose(ch0Active));
  cover property (busGrant[4]);
  cover property (cpuIrq[3]);
endmodule // fcd_dma_checker

// [verif/fcd_fifo_partner.sv]
// Far-side model: memory and peripheral FIFOs raising request lines
`timescale 1ns/100ps
module fcd_fifo_partner (
  input wire core_clk,
  input wire resetn,
  input wire [4:0] want,
  input wire slow,
  output reg [4:0] drqLine
);
  reg phase;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 1'b0;
      drqLine <= 5'h00;
    end else begin
      phase <= ~phase;
      // A slow FIFO asks only every other cycle, so grants arrive with gaps
      drqLine <= (slow && phase) ? 5'h00 : want;
    end
  end
endmodule // fcd_fifo_partner

// [verif/test_fcd_dma_ctrl.sv]
// Self-checking bench for the DMA control block
`timescale 1ns/100ps
`include "fcd_dma_defines.vh"
module test_fcd_dma_ctrl;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg [8:0] regAddr = 9'h000;
  reg [31:0] regWrData = 32'h0;
  reg regWrEn = 1'b0;
  reg regRdEn = 1'b0;
  reg [4:1] chRun = 4'h0;
  reg [4:1] chHalfEvt = 4'h0;
  reg [4:1] chDoneEvt = 4'h0;
  reg ch0Error = 1'b0;
  reg [4:0] want = 5'h00;
  reg slow = 1'b0;
  wire [31:0] regRdData;
  wire [4:0] drqLine, busGrant, cpuIrq;
  wire [18:0] ch0SrcAddr, ch0DstAddr;
  wire [2:0] ch0WidthBytes;
  wire ch0Active;
  integer err_count = 0;
  integer check_count = 0;
  integer i;
  // Width in bits 15:13, control word below
  logic [15:0] kindTab [9] = '{16'h7501, 16'h4501, 16'h9091, 16'h2091, 16'h40A1,
                              16'h4C01, 16'h2301, 16'h2081, 16'h8061};
  always #4 core_clk = ~core_clk;
  fcd_dma_ctrl uut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .drqLine(drqLine), .chRun(chRun), .chHalfEvt(chHalfEvt), .chDoneEvt(chDoneEvt),
    .ch0Error(ch0Error), .busGrant(busGrant), .ch0SrcAddr(ch0SrcAddr),
    .ch0DstAddr(ch0DstAddr), .ch0WidthBytes(ch0WidthBytes), .ch0Active(ch0Active),
    .cpuIrq(cpuIrq));
  fcd_fifo_partner far (.core_clk(core_clk), .resetn(resetn), .want(want), .slow(slow),
    .drqLine(drqLine));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [8:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge core_clk);
      regWrEn <= 1'b0;
    end
  endtask
  task rd(input [8:0] a, input [31:0] exp);
    begin
      @(posedge core_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      #1;
      chk(regRdData, exp);
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task pulse(input [4:1] h, input [4:1] d);
    begin
      @(posedge core_clk);
      chHalfEvt <= h;
      chDoneEvt <= d;
      @(posedge core_clk);
      chHalfEvt <= 4'h0;
      chDoneEvt <= 4'h0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`FCD_OFS_RANK, 32'h0);
    rd(`FCD_OFS_PEND, 32'h0);
    rd(`FCD_OFS_IEN, 32'h0);
    rd(`FCD_OFS_CTL0, 32'h0);
    rd(9'h00C, 32'h0);
    @(posedge core_clk);
    chRun <= 4'hF;
    want <= 5'h1E;
    for (i = 0; i < 8; i = i + 1) begin
      wr(`FCD_OFS_RANK, i);
      tick(3);
      chk(busGrant, (i >= 1 && i <= 4) ? 5'h01 << i : 5'h02);
    end
    wr(`FCD_OFS_RANK, 32'hFFFF_FFFF);
    rd(`FCD_OFS_RANK, 32'h7);
    @(posedge core_clk);
    chRun <= 4'h0;
    want <= 5'h00;
    wr(`FCD_OFS_IEN, 32'hFFFF_FFFF);
    rd(`FCD_OFS_IEN, 32'h0000_1F1F);
    pulse(4'h2, 4'h4);
    tick(2);
    chk(cpuIrq, 5'h0C);
    rd(`FCD_OFS_PEND, 32'h0000_0408);
    wr(`FCD_OFS_PEND, 32'h0);
    rd(`FCD_OFS_PEND, 32'h0000_0408);
    wr(`FCD_OFS_PEND, 32'h0000_0400);
    rd(`FCD_OFS_PEND, 32'h0000_0008);
    wr(`FCD_OFS_IEN, 32'h0000_1F00);
    pulse(4'h0, 4'h1);
    tick(2);
    chk(cpuIrq, 5'h00);
    rd(`FCD_OFS_PEND, 32'h0000_000A);
    wr(`FCD_OFS_PEND, 32'hFFFF_FFFF);
    rd(`FCD_OFS_PEND, 32'h0);
    // Memory to memory frame of 8 bytes with a slow requester
    wr(`FCD_OFS_SRC0, 32'h0000_0103);
    wr(`FCD_OFS_DST0, 32'h0000_0207);
    wr(`FCD_OFS_LEN0, 32'h0000_0008);
    wr(`FCD_OFS_IEN, 32'h0000_0101);
    wr(`FCD_OFS_CTL0, 32'h0000_0001);
    tick(1);
    chk(ch0Active, 1'b1);
    chk(ch0SrcAddr, 19'h00100);
    chk(ch0DstAddr, 19'h00204);
    rd(`FCD_OFS_REM0, 32'h8);
    @(posedge core_clk);
    want <= 5'h01;
    slow <= 1'b1;
    for (i = 0; i < 60 && ch0Active === 1'b1; i = i + 1) @(posedge core_clk);
    chk(ch0Active, 1'b0);
    rd(`FCD_OFS_PEND, 32'h0000_0101);
    rd(`FCD_OFS_CTL0, 32'h0);
    rd(`FCD_OFS_REM0, 32'h0);
    chk(cpuIrq, 5'h01);
    chk(ch0SrcAddr, 19'h00108);
    chk(ch0DstAddr, 19'h0020C);
    wr(`FCD_OFS_PEND, 32'hFFFF_FFFF);
    @(posedge core_clk);
    want <= 5'h00;
    slow <= 1'b0;
    // Each kind pairing in kindTab starts, shows its width, then is aborted
    for (i = 0; i < 9; i = i + 1) begin
      wr(`FCD_OFS_CTL0, kindTab[i][12:0]);
      tick(1);
      chk(ch0WidthBytes, kindTab[i][15:13]);
      wr(`FCD_OFS_CTL0, kindTab[i][12:1] << 1);
      tick(1);
      chk(ch0Active, 1'b0);
    end
    rd(`FCD_OFS_PEND, 32'h0);
    // A FIFO end counts one per access, whatever the width
    wr(`FCD_OFS_CTL0, 32'h0000_0C01);
    @(posedge core_clk);
    want <= 5'h01;
    @(posedge core_clk);
    want <= 5'h00;
    rd(`FCD_OFS_REM0, 32'h7);
    wr(`FCD_OFS_CTL0, 32'h0000_0C00);
    wr(`FCD_OFS_CTL0, 32'h0000_0001);
    @(posedge core_clk);
    ch0Error <= 1'b1;
    @(posedge core_clk);
    ch0Error <= 1'b0;
    tick(1);
    chk(ch0Active, 1'b0);
    rd(`FCD_OFS_CTL0, 32'h0);
    wr(`FCD_OFS_CTL0, 32'h0000_0003);
    @(posedge core_clk);
    want <= 5'h01;
    for (i = 0; i < 60 && cpuIrq[0] !== 1'b1; i = i + 1) @(posedge core_clk);
    want <= 5'h00;
    tick(2);
    chk(ch0Active, 1'b1);
    rd(`FCD_OFS_CTL0, 32'h0000_0003);
    wr(`FCD_OFS_CTL0, 32'h0000_0002);
    tick(2);
    chk(ch0Active, 1'b0);
    give_verdict;
  end
  initial begin
    #50000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule // test_fcd_dma_ctrl
bind fcd_dma_ctrl fcd_dma_checker chk_i (.core_clk(core_clk), .resetn(resetn),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .drqLine(drqLine), .chRun(chRun), .chHalfEvt(chHalfEvt),
  .chDoneEvt(chDoneEvt), .ch0Error(ch0Error), .busGrant(busGrant), .ch0SrcAddr(ch0SrcAddr),
  .ch0DstAddr(ch0DstAddr), .ch0WidthBytes(ch0WidthBytes), .ch0Active(ch0Active),
  .cpuIrq(cpuIrq));
